// [src/rst_pkg.sv]
// Constants and types for the reset source tracker
package rst_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADR_CAUSE = 8'h00;
  localparam logic [7:0] ADR_WDCS = 8'h04;
  localparam logic [7:0] ADR_WDCNT = 8'h08;
  localparam logic [7:0] ADR_WDCLK = 8'h0C;
  localparam logic [7:0] ADR_BOCTL = 8'h10;
  localparam logic [7:0] ADR_ISTAT = 8'h14;
  localparam logic [7:0] ADR_ICLR = 8'h18;
  localparam logic [7:0] ADR_IEN = 8'h1C;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CAUSE_POR_BIT = 1;
  localparam int CAUSE_WD_BIT = 0;
  localparam int WDCS_CNTWE_LOCK = 7;
  localparam int WDCS_CNTWE = 6;
  localparam int WDCS_CSRWE_LOCK = 5;
  localparam int WDCS_CSRWE = 4;
  localparam int WDCS_ON_LOCK = 3;
  localparam int WDCS_ON = 2;
  localparam int WDCS_FLAG_LOCK = 1;
  localparam int WDCS_FLAG = 0;
  localparam int BOCTL_INT_BIT = 5;
  localparam int BOCTL_LVL_BIT = 3;
  // ----------------------------------------
  // Reset values, divider code and count limit
  // ----------------------------------------
  localparam logic WDON_RST = 1'b1;
  localparam logic [3:0] WDCLK_RST = 4'hF;
  localparam logic [3:0] WDCLK_DIV8192 = 4'hF;
  localparam logic [7:0] BOCTL_RST = 8'h28;
  localparam logic [7:0] WDCNT_RST = 8'h00;
  localparam logic [7:0] WD_MAX = 8'hFF;
  // ----------------------------------------
  // Counter widths and timing counts
  // ----------------------------------------
  localparam int PRESC_WIDTH = 13;
  localparam int DLY_WIDTH = 18;
  localparam int WD_DIV_CYCLES = 8192;
  localparam int BO_DELAY_CYCLES = 131072;
  localparam int WD_RST_CYCLES = 4;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_RUN = 3'b001,
    ST_BROWN = 3'b010,
    ST_BODLY = 3'b011,
    ST_EXT = 3'b100,
    ST_WD = 3'b101
  } rst_state_e;
  typedef struct packed {
    logic wd;
    logic ext;
    logic bo;
  } rst_evt_s;
endpackage

// [src/rst_source_tracker.sv]
// Reset generation, reset cause flags and watchdog
`timescale 1ns/10ps
// Behaviour
// - Supply at or below detect level asserts internal reset.
// - On supply recovery restart prescaler, release after 131072 clocks.
// - Power-on reset holds internal reset until it is released.
// - Watchdog counts up after power-on release with no software action.
// - Watchdog overflow asserts internal reset.
// - Low external reset pin puts device into reset.
// - Cause flags: 10 power/brownout, 00 pin, 01 watchdog.
// - Upper six cause register bits reserved, read zero.
// - Prescaler is 13-bit, increments every clock.
// - Watchdog counter 8-bit read/write, ticks at clock over 8192.
// - Watchdog enabled from reset, runs automatically on release.
// - Watchdog control gates its own and counter writes, shows state.
// - Brownout control sets detector options and level select.
// - Power/brownout flag set by that reset, cleared by writing zero.
// - Watchdog flag set by watchdog, cleared by other resets or zero.
// - Counter wrap FF to 00 is the overflow.
module rst_source_tracker #(
  parameter int BO_DELAY_CYCLES = rst_pkg::BO_DELAY_CYCLES,
  parameter int WD_DIV_CYCLES = rst_pkg::WD_DIV_CYCLES
) (
  // Clock and power-on reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Reset sources
  input wire logic supply_low_in,
  input wire logic ext_reset_n_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Status outputs
  output logic internal_reset_out,
  output logic level_select_out,
  output logic ext_compare_off_out,
  output logic irq_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  rst_pkg::rst_state_e state_q;
  rst_pkg::rst_state_e state_d;
  rst_pkg::rst_evt_s evt;
  logic [rst_pkg::PRESC_WIDTH-1:0] presc_q;
  logic [rst_pkg::DLY_WIDTH-1:0] dly_q;
  logic [7:0] wd_cnt_q;
  logic [3:0] wd_clk_q;
  logic [7:0] boctl_q;
  logic [2:0] istat_q;
  logic [2:0] ien_q;
  logic wd_on_q;
  logic cnt_we_q;
  logic csr_we_q;
  logic por_flag_q;
  logic wd_flag_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic take;
  logic wr;
  logic [7:0] wdat;
  logic tick;
  logic wd_ovf;
  logic bo_start;

  localparam logic [rst_pkg::PRESC_WIDTH-1:0] PRESC_LAST =
    rst_pkg::PRESC_WIDTH'(WD_DIV_CYCLES - 1);
  localparam logic [rst_pkg::DLY_WIDTH-1:0] BO_LAST =
    rst_pkg::DLY_WIDTH'(BO_DELAY_CYCLES - 1);
  localparam logic [rst_pkg::DLY_WIDTH-1:0] WD_LAST =
    rst_pkg::DLY_WIDTH'(rst_pkg::WD_RST_CYCLES - 1);

  function automatic logic wr_to(input logic [7:0] adr);
    wr_to = wr && (wb_adr_in == adr);
  endfunction

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  assign take = wb_cyc_in && wb_stb_in && !ack_q;
  assign wr = take && wb_we_in && wb_sel_in[0];
  assign wdat = wb_dat_in[7:0];
  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdat_q <= 32'h0;
    end else if (take && !wb_we_in) begin
      case (wb_adr_in)
        rst_pkg::ADR_CAUSE: rdat_q <= {30'h0, por_flag_q, wd_flag_q};
        rst_pkg::ADR_WDCS: rdat_q <= {24'h0, 1'b1, cnt_we_q, 1'b1, csr_we_q,
                                      1'b1, wd_on_q, 1'b1, wd_flag_q};
        rst_pkg::ADR_WDCNT: rdat_q <= {24'h0, wd_cnt_q};
        rst_pkg::ADR_WDCLK: rdat_q <= {28'h0, wd_clk_q};
        rst_pkg::ADR_BOCTL: rdat_q <= {24'h0, boctl_q};
        rst_pkg::ADR_ISTAT: rdat_q <= {29'h0, istat_q};
        rst_pkg::ADR_IEN: rdat_q <= {29'h0, ien_q};
        default: rdat_q <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    if (supply_low_in) begin
      state_d = rst_pkg::ST_BROWN;
    end else if (!ext_reset_n_in) begin
      state_d = rst_pkg::ST_EXT;
    end else begin
      case (state_q)
        rst_pkg::ST_POR: state_d = rst_pkg::ST_RUN;
        rst_pkg::ST_BROWN: state_d = rst_pkg::ST_BODLY;
        rst_pkg::ST_BODLY: begin
          if (dly_q == BO_LAST) begin
            state_d = rst_pkg::ST_RUN;
          end
        end
        rst_pkg::ST_EXT: state_d = rst_pkg::ST_RUN;
        rst_pkg::ST_WD: begin
          if (dly_q == WD_LAST) begin
            state_d = rst_pkg::ST_RUN;
          end
        end
        rst_pkg::ST_RUN: begin
          if (wd_ovf) begin
            state_d = rst_pkg::ST_WD;
          end
        end
        default: state_d = rst_pkg::ST_POR;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= rst_pkg::ST_POR;
    end else begin
      state_q <= state_d;
    end
  end

  // Any source not in run holds the reset
  assign internal_reset_out = (state_q != rst_pkg::ST_RUN);
  assign bo_start = (state_q == rst_pkg::ST_BROWN) && (state_d == rst_pkg::ST_BODLY);

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dly_q <= '0;
    end else if (state_d != state_q) begin
      dly_q <= '0;
    end else begin
      dly_q <= dly_q + 1'b1;
    end
  end

  // ----------------------------------------
  // Prescaler and watchdog
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      presc_q <= '0;
    end else if (bo_start || presc_q == PRESC_LAST) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  assign tick = (presc_q == PRESC_LAST) && (wd_clk_q == rst_pkg::WDCLK_DIV8192);
  assign wd_ovf = tick && wd_on_q && (wd_cnt_q == rst_pkg::WD_MAX);

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wd_cnt_q <= rst_pkg::WDCNT_RST;
    end else if (internal_reset_out) begin
      wd_cnt_q <= rst_pkg::WDCNT_RST;
    end else if (wr_to(rst_pkg::ADR_WDCNT) && cnt_we_q) begin
      wd_cnt_q <= wdat;
    end else if (tick && wd_on_q) begin
      wd_cnt_q <= wd_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wd_on_q <= rst_pkg::WDON_RST;
      cnt_we_q <= 1'b0;
      csr_we_q <= 1'b0;
    end else if (internal_reset_out) begin
      wd_on_q <= rst_pkg::WDON_RST;
      cnt_we_q <= 1'b0;
      csr_we_q <= 1'b0;
    end else if (wr_to(rst_pkg::ADR_WDCS)) begin
      if (!wdat[rst_pkg::WDCS_CNTWE_LOCK]) begin
        cnt_we_q <= wdat[rst_pkg::WDCS_CNTWE];
      end
      if (!wdat[rst_pkg::WDCS_CSRWE_LOCK]) begin
        csr_we_q <= wdat[rst_pkg::WDCS_CSRWE];
      end
      if (!wdat[rst_pkg::WDCS_ON_LOCK] && csr_we_q) begin
        wd_on_q <= wdat[rst_pkg::WDCS_ON];
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wd_clk_q <= rst_pkg::WDCLK_RST;
    end else if (wr_to(rst_pkg::ADR_WDCLK)) begin
      wd_clk_q <= wdat[3:0];
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boctl_q <= rst_pkg::BOCTL_RST;
    end else if (wr_to(rst_pkg::ADR_BOCTL)) begin
      boctl_q <= {2'b00, wdat[rst_pkg::BOCTL_INT_BIT], 1'b0,
                  wdat[rst_pkg::BOCTL_LVL_BIT], 3'b000};
    end
  end
  assign level_select_out = boctl_q[rst_pkg::BOCTL_LVL_BIT];
  assign ext_compare_off_out = boctl_q[rst_pkg::BOCTL_INT_BIT];

  // ----------------------------------------
  // Cause flags
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      por_flag_q <= 1'b1;
    end else if (state_q == rst_pkg::ST_BROWN) begin
      por_flag_q <= 1'b1;
    end else if (wr_to(rst_pkg::ADR_CAUSE) && !wdat[rst_pkg::CAUSE_POR_BIT]) begin
      por_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wd_flag_q <= 1'b0;
    end else if (wd_ovf && state_q == rst_pkg::ST_RUN) begin
      wd_flag_q <= 1'b1;
    end else if (state_q == rst_pkg::ST_BROWN || state_q == rst_pkg::ST_EXT) begin
      wd_flag_q <= 1'b0;
    end else if (wr_to(rst_pkg::ADR_CAUSE) && !wdat[rst_pkg::CAUSE_WD_BIT]) begin
      wd_flag_q <= 1'b0;
    end else if (wr_to(rst_pkg::ADR_WDCS) && csr_we_q &&
                 !wdat[rst_pkg::WDCS_FLAG_LOCK] && !wdat[rst_pkg::WDCS_FLAG]) begin
      wd_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign evt.bo = (state_q != rst_pkg::ST_BROWN) && (state_d == rst_pkg::ST_BROWN);
  assign evt.ext = (state_q != rst_pkg::ST_EXT) && (state_d == rst_pkg::ST_EXT);
  assign evt.wd = (state_q != rst_pkg::ST_WD) && (state_d == rst_pkg::ST_WD);

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      istat_q <= 3'h0;
    end else if (wr_to(rst_pkg::ADR_ICLR)) begin
      istat_q <= (istat_q & ~wdat[2:0]) | evt;
    end else begin
      istat_q <= istat_q | evt;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ien_q <= 3'h0;
    end else if (wr_to(rst_pkg::ADR_IEN)) begin
      ien_q <= wdat[2:0];
    end
  end

  assign irq_out = |(istat_q & ien_q);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  a_bo_entry: assert property (supply_low_in |=> internal_reset_out ##1 !wd_flag_q)
    else $error("brownout did not reset");
  a_bo_release: assert property (state_q == rst_pkg::ST_BODLY && dly_q == BO_LAST &&
    !supply_low_in && ext_reset_n_in |=> !internal_reset_out)
    else $error("brownout delay release wrong");
  a_bo_hold: assert property (state_q == rst_pkg::ST_BODLY && dly_q != BO_LAST
    |=> internal_reset_out)
    else $error("brownout released early");
  a_por_release: assert property (reset_n_in && state_q == rst_pkg::ST_POR &&
    !supply_low_in && ext_reset_n_in |=> !internal_reset_out)
    else $error("power on release");
  a_wd_reset: assert property (wd_ovf && !internal_reset_out && !supply_low_in &&
    ext_reset_n_in |=> state_q == rst_pkg::ST_WD && wd_flag_q ##4 !internal_reset_out)
    else $error("watchdog overflow reset wrong");
  a_ext_enter: assert property (!ext_reset_n_in && !supply_low_in
    |=> state_q == rst_pkg::ST_EXT ##1 !wd_flag_q)
    else $error("pin reset not entered");
  a_ext_release: assert property (state_q == rst_pkg::ST_EXT && ext_reset_n_in &&
    !supply_low_in |=> !internal_reset_out)
    else $error("pin reset not released");
  a_cause_rsvd: assert property (ack_q && !wb_we_in && wb_adr_in == rst_pkg::ADR_CAUSE
    |-> rdat_q[31:2] == 30'h0)
    else $error("reserved cause bits set");
  a_presc_inc: assert property (reset_n_in && !bo_start && presc_q != PRESC_LAST
    |=> presc_q == $past(presc_q) + 1'b1)
    else $error("prescaler did not increment");
  a_wd_count: assert property (tick && wd_on_q && !internal_reset_out && !wr
    && wd_cnt_q != rst_pkg::WD_MAX |=> wd_cnt_q == $past(wd_cnt_q) + 8'h01)
    else $error("watchdog did not count");
  a_wd_on_reset: assert property (internal_reset_out |=> wd_on_q)
    else $error("watchdog not enabled by reset");

  c_wd_reset: cover property (state_q == rst_pkg::ST_WD);
  c_bo_done: cover property (state_q == rst_pkg::ST_BODLY ##1 state_q == rst_pkg::ST_RUN);
  c_ext_done: cover property (state_q == rst_pkg::ST_EXT ##1 state_q == rst_pkg::ST_RUN);

endmodule // rst_source_tracker

// [test/rst_far_model.sv]
// Model of the external reset pin driver and supply comparator
`timescale 1ns/10ps
module rst_far_model (
  // Clock
  input wire logic clock_in,
  // Driven lines
  output logic supply_low_out,
  output logic ext_reset_n_out
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    supply_low_out = 1'b0;
    ext_reset_n_out = 1'b1;
  end
  // ----------------------------------------
  // Pin pulse, held low the whole span
  // ----------------------------------------
  task automatic pin_pulse(input int n);
    @(posedge clock_in);
    ext_reset_n_out <= 1'b0;
    repeat (n) @(posedge clock_in);
    ext_reset_n_out <= 1'b1;
  endtask
  // ----------------------------------------
  // Supply dip below detect level
  // ----------------------------------------
  task automatic supply_dip(input int n);
    @(posedge clock_in);
    supply_low_out <= 1'b1;
    repeat (n) @(posedge clock_in);
    supply_low_out <= 1'b0;
  endtask
endmodule // rst_far_model

// [test/rst_source_tracker_tb_top.sv]
// Self-checking bench for the reset source tracker
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("Error %0t: got %0h want %0h", $time, a, b); end end
module rst_source_tracker_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int BO = 64;
  localparam int WD = 16;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic ack;
  logic int_rst;
  logic lvl_sel;
  logic cmp_off;
  logic irq;
  logic sup_low;
  logic pin_n;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic [31:0] rd2;
  int n;
  always #4 clock = ~clock;
  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  rst_source_tracker #(.BO_DELAY_CYCLES(BO), .WD_DIV_CYCLES(WD)) i_dut (
    .clock_in(clock), .reset_n_in(reset_n), .supply_low_in(sup_low),
    .ext_reset_n_in(pin_n), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat_w), .wb_dat_out(dat_r),
    .wb_ack_out(ack), .internal_reset_out(int_rst), .level_select_out(lvl_sel),
    .ext_compare_off_out(cmp_off), .irq_out(irq));
  rst_far_model i_far (.clock_in(clock), .supply_low_out(sup_low), .ext_reset_n_out(pin_n));
  // ----------------------------------------
  // Bus and wait tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    int k;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat_w <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) failures++;
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic wait_rst(input logic lvl, input int lim, output int k);
    k = 0;
    while (int_rst !== lvl && k < lim) begin
      @(posedge clock);
      k++;
    end
    if (k >= lim) failures++;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_on();
    wait_rst(1'b0, 10, n);
    bus(1'b0, rst_pkg::ADR_CAUSE, 8'h00, rd);
    `CHK(rd, 32'h02)
    bus(1'b0, rst_pkg::ADR_WDCS, 8'h00, rd);
    `CHK(rd, 32'hAE)
    bus(1'b0, rst_pkg::ADR_BOCTL, 8'h00, rd);
    `CHK(rd, 32'h28)
    `CHK(lvl_sel, 1'b1)
    `CHK(cmp_off, 1'b1)
    wr(rst_pkg::ADR_BOCTL, 8'h08);
    bus(1'b0, rst_pkg::ADR_BOCTL, 8'h00, rd);
    `CHK(rd, 32'h08)
    `CHK(cmp_off, 1'b0)
    `CHK(lvl_sel, 1'b1)
    bus(1'b0, 8'h24, 8'h00, rd);
    `CHK(rd, 32'h00)
    wr(rst_pkg::ADR_CAUSE, 8'h00);
    bus(1'b0, rst_pkg::ADR_CAUSE, 8'h00, rd);
    `CHK(rd, 32'h00)
  endtask
  task automatic t_watchdog();
    bus(1'b0, rst_pkg::ADR_WDCNT, 8'h00, rd);
    `CHK(rd != 32'h0, 1'b1)
    wr(rst_pkg::ADR_WDCNT, 8'hF0);
    bus(1'b0, rst_pkg::ADR_WDCNT, 8'h00, rd2);
    `CHK(rd2 == 32'hF0, 1'b0)
    wr(rst_pkg::ADR_WDCS, 8'h40);
    wr(rst_pkg::ADR_WDCNT, 8'hF0);
    bus(1'b0, rst_pkg::ADR_WDCNT, 8'h00, rd);
    `CHK(rd & 32'hFE, 32'hF0)
    wr(rst_pkg::ADR_IEN, 8'h04);
    wait_rst(1'b1, 20 * WD, n);
    `CHK(n > 14 * WD, 1'b1)
    wait_rst(1'b0, 20, n);
    `CHK(n, rst_pkg::WD_RST_CYCLES)
    bus(1'b0, rst_pkg::ADR_CAUSE, 8'h00, rd);
    `CHK(rd, 32'h01)
    bus(1'b0, rst_pkg::ADR_WDCS, 8'h00, rd);
    `CHK(rd & 32'hFE, 32'hAE)
    `CHK(irq, 1'b1)
    wr(rst_pkg::ADR_ICLR, 8'h04);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_pin();
    i_far.pin_pulse(6);
    `CHK(int_rst, 1'b1)
    wait_rst(1'b0, 4, n);
    bus(1'b0, rst_pkg::ADR_CAUSE, 8'h00, rd);
    `CHK(rd, 32'h00)
    bus(1'b0, rst_pkg::ADR_ISTAT, 8'h00, rd);
    `CHK(rd[1], 1'b1)
    `CHK(irq, 1'b0)
  endtask
  task automatic t_brownout();
    i_far.supply_dip(8);
    `CHK(int_rst, 1'b1)
    wait_rst(1'b0, BO + 10, n);
    `CHK(n >= BO && n <= BO + 3, 1'b1)
    bus(1'b0, rst_pkg::ADR_CAUSE, 8'h00, rd);
    `CHK(rd, 32'h02)
    bus(1'b0, rst_pkg::ADR_ISTAT, 8'h00, rd);
    `CHK(rd, 32'h03)
  endtask
  task automatic t_disable();
    wr(rst_pkg::ADR_WDCLK, 8'h00);
    bus(1'b0, rst_pkg::ADR_WDCNT, 8'h00, rd);
    repeat (4 * WD) @(posedge clock);
    bus(1'b0, rst_pkg::ADR_WDCNT, 8'h00, rd2);
    `CHK(rd2, rd)
    wr(rst_pkg::ADR_WDCLK, 8'h0F);
    bus(1'b0, rst_pkg::ADR_WDCLK, 8'h00, rd);
    `CHK(rd, 32'h0F)
    wr(rst_pkg::ADR_WDCS, 8'h10);
    wr(rst_pkg::ADR_WDCS, 8'hA2);
    bus(1'b0, rst_pkg::ADR_WDCS, 8'h00, rd);
    `CHK(rd & 32'hFE, 32'hBA)
    bus(1'b0, rst_pkg::ADR_WDCNT, 8'h00, rd);
    repeat (4 * WD) @(posedge clock);
    bus(1'b0, rst_pkg::ADR_WDCNT, 8'h00, rd2);
    `CHK(rd2, rd)
  endtask
  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic close_out();
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_power_on();
    t_watchdog();
    t_pin();
    t_brownout();
    t_disable();
    close_out();
  end
  initial begin
    #200000;
    failures++;
    close_out();
  end
endmodule // rst_source_tracker_tb_top
